/* File: shared/sfc_pkg.sv */
`default_nettype none
package sfc_pkg;

	// ==========================================================
	// Geometry.
	localparam int DATA_W   = 8;
	localparam int DEPTH    = 12;
	localparam int RD_W     = 8;
	localparam int RD_DEPTH = 12;
	localparam int ADDR_W   = 4;
	// Free-running counters wrap at a power of two above twice the depth.
	localparam int CNT_W    = 5;

	// ==========================================================
	// Storage blocks, cascaded in depth and in width.
	localparam int BLK_DEPTH = 8;
	localparam int BLK_AW    = 3;
	localparam int BLK_W     = 4;
	localparam int BLK_ROWS  = 2;
	localparam int BLK_COLS  = 2;

	// ==========================================================
	// Constants, thresholds and reset values.
	localparam logic [ADDR_W-1:0] LAST_ADDR   = 4'hb;
	localparam logic [CNT_W-1:0]  DEPTH_CNT   = 5'h0c;
	localparam logic [CNT_W-1:0]  AF_STATIC   = 5'h09;
	localparam logic [CNT_W-1:0]  AE_STATIC   = 5'h03;
	localparam logic [CNT_W-1:0]  RST_CNT     = 5'h00;
	localparam logic [ADDR_W-1:0] RST_ADDR    = 4'h0;
	localparam logic [DATA_W-1:0] RST_DATA    = 8'h00;
	localparam int                STAGE_DEPTH = 4;

	// ==========================================================
	// Gray conversion.
	function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b = '0;
		for (int i = CNT_W - 1; i >= 0; i--)
		begin
			b[i] = (i == CNT_W - 1) ? g[i] : (b[i+1] ^ g[i]);
		end
		return b;
	endfunction

endpackage
`default_nettype wire

/* File: shared/sfc_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfc_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: rtl/sfc_stage_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Small staging FIFO; depth must be a power of two.
module sfc_stage_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset.
	input  wire logic     clk_sys,
	input  wire logic     rstn,
	// Streams.
	sfc_stream_if.sink    in_s,
	sfc_stream_if.source  out_s
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D + 1);

	logic [W-1:0]  mem [D];
	logic [PW-1:0] wptr;
	logic [PW-1:0] rptr;
	logic [CW-1:0] count;
	logic          push;
	logic          pop;

	assign in_s.ready  = (count != CW'(D));
	assign out_s.valid = (count != '0);
	assign out_s.data  = mem[rptr];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wptr] <= in_s.data;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end
		else
		begin
			wptr  <= wptr + PW'(push);
			rptr  <= rptr + PW'(pop);
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/sfc_fifo_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo_ctrl #(
	parameter bit DUAL_CLOCK     = 1'b0,
	parameter bit EXT_MEM        = 1'b0,
	parameter bit WR_WHEN_FULL   = 1'b0,
	parameter bit RD_WHEN_EMPTY  = 1'b0,
	parameter bit AF_DYNAMIC     = 1'b0,
	parameter bit AE_DYNAMIC     = 1'b0
) (
	// Clocks and reset.
	input  wire logic                        clk_sys,
	input  wire logic                        read_side_clock,
	input  wire logic                        rstn,
	// Write client.
	input  wire logic                        write_request,
	input  wire logic [sfc_pkg::DATA_W-1:0]  write_data,
	output logic                             write_ready,
	output logic                             write_accepted_strobe,
	output logic                             overflow,
	output logic                             full,
	output logic                             almost_full_flag,
	output logic [sfc_pkg::CNT_W-1:0]        write_level,
	input  wire logic [sfc_pkg::CNT_W-1:0]   almost_full_threshold_in,
	// Read client.
	input  wire logic                        read_request,
	output logic [sfc_pkg::RD_W-1:0]         read_data,
	output logic                             read_valid_strobe,
	output logic                             underflow,
	output logic                             empty,
	output logic                             almost_empty_flag,
	output logic [sfc_pkg::CNT_W-1:0]        read_level,
	input  wire logic [sfc_pkg::CNT_W-1:0]   almost_empty_threshold_in,
	// External memory.
	output logic [sfc_pkg::ADDR_W-1:0]       ext_mem_write_addr,
	output logic                             ext_mem_write_en,
	output logic [sfc_pkg::DATA_W-1:0]       ext_mem_write_data,
	output logic [sfc_pkg::ADDR_W-1:0]       ext_mem_read_addr,
	output logic                             ext_mem_read_en,
	input  wire logic [sfc_pkg::RD_W-1:0]    ext_mem_read_data
);
	// ==========================================================
	// Configuration check and clocks.
	if (sfc_pkg::DATA_W * sfc_pkg::DEPTH != sfc_pkg::RD_W * sfc_pkg::RD_DEPTH)
	begin : g_ratio
		$error("Write and read aspect ratios do not hold the same bits.");
	end

	logic rclk;
	// A plain mux keeps one code path; single clock collapses both domains.
	assign rclk = DUAL_CLOCK ? read_side_clock : clk_sys;

	// ==========================================================
	// Staging buffer in front of the write port.
	sfc_stream_if #(.W(sfc_pkg::DATA_W)) stg_in ();
	sfc_stream_if #(.W(sfc_pkg::DATA_W)) stg_out ();

	assign stg_in.valid = write_request;
	assign stg_in.data  = write_data;
	assign write_ready  = stg_in.ready;

	sfc_stage_fifo #(
		.W (sfc_pkg::DATA_W),
		.D (sfc_pkg::STAGE_DEPTH)
	) u_stage (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.in_s    (stg_in),
		.out_s   (stg_out)
	);

	// ==========================================================
	// Write side.
	logic [sfc_pkg::CNT_W-1:0]  wcnt;
	logic [sfc_pkg::CNT_W-1:0]  next_wcnt;
	logic [sfc_pkg::ADDR_W-1:0] waddr;
	logic [sfc_pkg::ADDR_W-1:0] next_waddr;
	logic [sfc_pkg::CNT_W-1:0]  rview_w;
	logic [sfc_pkg::CNT_W-1:0]  occ_w;
	logic [sfc_pkg::CNT_W-1:0]  af_thr;
	logic                       wr_store;
	logic                       wr_adv;

	// Words that stall here back-pressure the client through the staging buffer.
	assign stg_out.ready = !full || WR_WHEN_FULL;
	assign wr_store      = stg_out.valid && stg_out.ready;
	assign wr_adv        = stg_out.valid && !full;
	assign next_wcnt     = wcnt + sfc_pkg::CNT_W'(wr_adv);
	// Explicit wrap at the last address allows any depth.
	assign next_waddr    = !wr_adv ? waddr :
		(waddr == sfc_pkg::LAST_ADDR) ? sfc_pkg::RST_ADDR : waddr + 4'h1;
	assign occ_w         = next_wcnt - rview_w;
	assign af_thr        = AF_DYNAMIC ? almost_full_threshold_in : sfc_pkg::AF_STATIC;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wcnt  <= sfc_pkg::RST_CNT;
			waddr <= sfc_pkg::RST_ADDR;
		end
		else
		begin
			wcnt  <= next_wcnt;
			waddr <= next_waddr;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			full             <= 1'b0;
			almost_full_flag <= 1'b0;
			write_level      <= sfc_pkg::RST_CNT;
		end
		else
		begin
			full             <= (occ_w == sfc_pkg::DEPTH_CNT);
			almost_full_flag <= (occ_w >= af_thr);
			write_level      <= occ_w;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			write_accepted_strobe <= 1'b0;
			overflow              <= 1'b0;
		end
		else
		begin
			write_accepted_strobe <= wr_store;
			overflow              <= write_request && !stg_in.ready;
		end
	end

	// ==========================================================
	// Read side.
	logic [sfc_pkg::CNT_W-1:0]  rcnt;
	logic [sfc_pkg::CNT_W-1:0]  next_rcnt;
	logic [sfc_pkg::ADDR_W-1:0] raddr;
	logic [sfc_pkg::ADDR_W-1:0] next_raddr;
	logic [sfc_pkg::CNT_W-1:0]  wview_r;
	logic [sfc_pkg::CNT_W-1:0]  occ_r;
	logic [sfc_pkg::CNT_W-1:0]  ae_thr;
	logic [sfc_pkg::RD_W-1:0]   stage_q;
	logic                       rd_do;
	logic                       rd_adv;
	logic                       rd_pend;

	// An empty read in the permissive mode replays the head without moving.
	assign rd_do      = read_request && (!empty || RD_WHEN_EMPTY);
	assign rd_adv     = read_request && !empty;
	assign next_rcnt  = rcnt + sfc_pkg::CNT_W'(rd_adv);
	assign next_raddr = !rd_adv ? raddr :
		(raddr == sfc_pkg::LAST_ADDR) ? sfc_pkg::RST_ADDR : raddr + 4'h1;
	assign occ_r      = wview_r - next_rcnt;
	assign ae_thr     = AE_DYNAMIC ? almost_empty_threshold_in : sfc_pkg::AE_STATIC;

	always_ff @(posedge rclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rcnt  <= sfc_pkg::RST_CNT;
			raddr <= sfc_pkg::RST_ADDR;
		end
		else
		begin
			rcnt  <= next_rcnt;
			raddr <= next_raddr;
		end
	end

	always_ff @(posedge rclk or negedge rstn)
	begin
		if (!rstn)
		begin
			empty             <= 1'b1;
			almost_empty_flag <= 1'b1;
			read_level        <= sfc_pkg::RST_CNT;
			underflow         <= 1'b0;
		end
		else
		begin
			empty             <= (occ_r == sfc_pkg::RST_CNT);
			almost_empty_flag <= (occ_r <= ae_thr);
			read_level        <= occ_r;
			underflow         <= read_request && !rd_do;
		end
	end

	// Two-stage read pipe: storage register, then the output register.
	always_ff @(posedge rclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_pend           <= 1'b0;
			read_valid_strobe <= 1'b0;
			read_data         <= sfc_pkg::RST_DATA;
		end
		else
		begin
			rd_pend           <= rd_do;
			read_valid_strobe <= rd_pend;
			if (rd_pend)
				read_data <= stage_q;
		end
	end

	// ==========================================================
	// Pointer exchange between the domains.
	if (DUAL_CLOCK)
	begin : g_sync
		logic [sfc_pkg::CNT_W-1:0] wgray;
		logic [sfc_pkg::CNT_W-1:0] rgray;
		logic [sfc_pkg::CNT_W-1:0] wg_s1;
		logic [sfc_pkg::CNT_W-1:0] wg_s2;
		logic [sfc_pkg::CNT_W-1:0] rg_s1;
		logic [sfc_pkg::CNT_W-1:0] rg_s2;

		// Only one bit moves per step, so a torn sample is off by at most one.
		always_ff @(posedge clk_sys or negedge rstn)
		begin
			if (!rstn)
			begin
				wgray <= sfc_pkg::RST_CNT;
				rg_s1 <= sfc_pkg::RST_CNT;
				rg_s2 <= sfc_pkg::RST_CNT;
			end
			else
			begin
				wgray <= sfc_pkg::bin2gray(next_wcnt);
				rg_s1 <= rgray;
				rg_s2 <= rg_s1;
			end
		end

		always_ff @(posedge rclk or negedge rstn)
		begin
			if (!rstn)
			begin
				rgray <= sfc_pkg::RST_CNT;
				wg_s1 <= sfc_pkg::RST_CNT;
				wg_s2 <= sfc_pkg::RST_CNT;
			end
			else
			begin
				rgray <= sfc_pkg::bin2gray(next_rcnt);
				wg_s1 <= wgray;
				wg_s2 <= wg_s1;
			end
		end

		assign rview_w = sfc_pkg::gray2bin(rg_s2);
		assign wview_r = sfc_pkg::gray2bin(wg_s2);
	end
	else
	begin : g_direct
		// Same clock: each side sees the other's next count directly.
		assign rview_w = next_rcnt;
		assign wview_r = next_wcnt;
	end

	// ==========================================================
	// Storage.
	if (EXT_MEM)
	begin : g_ext
		assign ext_mem_write_addr = waddr;
		assign ext_mem_write_en   = wr_store;
		assign ext_mem_write_data = stg_out.data;
		assign ext_mem_read_addr  = raddr;
		assign ext_mem_read_en    = rd_do;
		// The external RAM answers one read-clock cycle after its enable.
		assign stage_q            = ext_mem_read_data;
	end
	else
	begin : g_int
		logic [sfc_pkg::RD_W-1:0]  row_q [sfc_pkg::BLK_ROWS];
		logic                      rrow;

		for (genvar g = 0; g < sfc_pkg::BLK_ROWS * sfc_pkg::BLK_COLS; g++)
		begin : g_blk
			localparam int ROW = g / sfc_pkg::BLK_COLS;
			localparam int COL = g % sfc_pkg::BLK_COLS;
			logic [sfc_pkg::BLK_W-1:0] cells [sfc_pkg::BLK_DEPTH];
			// Each block owns its output register, so no array has two writing processes.
			logic [sfc_pkg::BLK_W-1:0] blk_q;

			// Upper address bit selects the row of blocks.
			always_ff @(posedge clk_sys)
			begin
				if (wr_store && (waddr[sfc_pkg::ADDR_W-1] == 1'(ROW)))
					cells[waddr[sfc_pkg::BLK_AW-1:0]] <=
						stg_out.data[COL*sfc_pkg::BLK_W +: sfc_pkg::BLK_W];
			end

			always_ff @(posedge rclk)
			begin
				if (rd_do)
					blk_q <= cells[raddr[sfc_pkg::BLK_AW-1:0]];
			end

			assign row_q[ROW][COL*sfc_pkg::BLK_W +: sfc_pkg::BLK_W] = blk_q;
		end

		always_ff @(posedge rclk or negedge rstn)
		begin
			if (!rstn)
				rrow <= 1'b0;
			else if (rd_do)
				rrow <= raddr[sfc_pkg::ADDR_W-1];
		end

		assign stage_q            = row_q[rrow];
		assign ext_mem_write_addr = sfc_pkg::RST_ADDR;
		assign ext_mem_write_en   = 1'b0;
		assign ext_mem_write_data = sfc_pkg::RST_DATA;
		assign ext_mem_read_addr  = sfc_pkg::RST_ADDR;
		assign ext_mem_read_en    = 1'b0;
	end
endmodule
`default_nettype wire

/* File: test/sfc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// External storage behind the controller.
module sfc_mem_model (
	// Clock.
	input wire logic			clk_sys,
	// Write port.
	input wire logic			write_en,
	input wire logic [sfc_pkg::ADDR_W-1:0]	write_addr,
	input wire logic [sfc_pkg::DATA_W-1:0]	write_data,
	// Read port.
	input wire logic			read_en,
	input wire logic [sfc_pkg::ADDR_W-1:0]	read_addr,
	output logic [sfc_pkg::RD_W-1:0]	read_data
);
	logic [sfc_pkg::DATA_W-1:0]	mem [16];

	initial read_data = 8'h00;
	// Idle cycles flip the word, so a stale value never passes for a fresh one.
	always @(posedge clk_sys)
	begin
		if (write_en)
			mem[write_addr] <= write_data;
		read_data <= read_en ? mem[read_addr] : ~read_data;
	end
endmodule
`default_nettype wire

/* File: test/sfc_fifo_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port relations of the FIFO controller.
module sfc_fifo_ctrl_properties (
	// Clock and reset.
	input wire logic			clk_sys,
	input wire logic			rstn,
	// Write side.
	input wire logic			write_request,
	input wire logic			write_ready,
	input wire logic			write_accepted_strobe,
	input wire logic			overflow,
	input wire logic			full,
	input wire logic			almost_full_flag,
	input wire logic [sfc_pkg::CNT_W-1:0]	write_level,
	input wire logic [sfc_pkg::CNT_W-1:0]	almost_full_threshold_in,
	// Read side.
	input wire logic			read_request,
	input wire logic [sfc_pkg::RD_W-1:0]	read_data,
	input wire logic			read_valid_strobe,
	input wire logic			underflow,
	input wire logic			empty,
	input wire logic			almost_empty_flag,
	input wire logic [sfc_pkg::CNT_W-1:0]	read_level,
	input wire logic [sfc_pkg::CNT_W-1:0]	almost_empty_threshold_in,
	// External memory.
	input wire logic			ext_mem_write_en,
	input wire logic			ext_mem_read_en
);
	logic	acc1;
	logic	acc2;

	// Accepted reads delayed to the cycle their data is due.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			acc1 <= 1'b0;
			acc2 <= 1'b0;
		end
		else
		begin
			acc1 <= read_request && !empty;
			acc2 <= acc1;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_OVF_PULSE: assert property (write_request && !write_ready |=> overflow)
		else $error("overflow missing after refused write");
	AST_OVF_QUIET: assert property (!(write_request && !write_ready) |=> !overflow)
		else $error("overflow without refused write");
	AST_FULL_LEVEL: assert property (full == (write_level == sfc_pkg::DEPTH_CNT))
		else $error("full disagrees with level");
	AST_EMPTY_LEVEL: assert property (empty == (read_level == sfc_pkg::RST_CNT))
		else $error("empty disagrees with level");
	AST_AF_LEVEL: assert property (almost_full_flag == (write_level >= almost_full_threshold_in))
		else $error("almost full flag wrong");
	AST_AE_LEVEL: assert property (almost_empty_flag == (read_level <= almost_empty_threshold_in))
		else $error("almost empty flag wrong");
	AST_RD_STROBE: assert property (read_valid_strobe == acc2)
		else $error("read strobe not two cycles after read");
	AST_RD_HOLD: assert property (!read_valid_strobe |-> $stable(read_data))
		else $error("read data moved without strobe");
	AST_STORE_ACK: assert property (ext_mem_write_en |=> write_accepted_strobe)
		else $error("store not acknowledged");
	AST_STORE_ROOM: assert property (ext_mem_write_en |-> !full)
		else $error("store while full");
	AST_FETCH_OK: assert property (ext_mem_read_en |-> read_request && !empty)
		else $error("fetch without accepted read");
	AST_UDF_PULSE: assert property (read_request && empty |=> underflow)
		else $error("underflow missing");
endmodule

bind sfc_fifo_ctrl sfc_fifo_ctrl_properties u_props (.clk_sys, .rstn, .write_request, .write_ready,
	.write_accepted_strobe, .overflow, .full, .almost_full_flag, .write_level, .almost_full_threshold_in,
	.read_request, .read_data, .read_valid_strobe, .underflow, .empty, .almost_empty_flag, .read_level,
	.almost_empty_threshold_in, .ext_mem_write_en, .ext_mem_read_en);
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Random traffic through the controller and its external storage.
module tb;
	logic		clk_sys = 1'b0;
	logic		rstn = 1'b0;
	logic		write_request = 1'b0;
	logic		read_request = 1'b0;
	logic [7:0]	write_data = 8'h00;
	logic [4:0]	almost_full_threshold_in = 5'h09;
	logic [4:0]	almost_empty_threshold_in = 5'h03;
	logic		write_ready, write_accepted_strobe, overflow, full, almost_full_flag;
	logic		read_valid_strobe, underflow, empty, almost_empty_flag;
	logic		ext_mem_write_en, ext_mem_read_en;
	logic [4:0]	write_level, read_level;
	logic [3:0]	ext_mem_write_addr, ext_mem_read_addr;
	logic [7:0]	read_data, ext_mem_write_data, ext_mem_read_data;
	logic [7:0]	q [$];
	logic [7:0]	qi [$];
	logic		im_ready, im_full, im_valid, im_empty;
	logic [7:0]	im_read_data;
	logic		ovf_e = 1'b0;
	logic		udf_e = 1'b0;
	int		fails = 0;
	int		checks_done = 0;
	int		taken = 0;
	int		acks = 0;

	sfc_fifo_ctrl #(.EXT_MEM(1'b1), .AF_DYNAMIC(1'b1), .AE_DYNAMIC(1'b1)) dut (.clk_sys,
		.read_side_clock(clk_sys), .rstn, .write_request, .write_data, .write_ready, .write_accepted_strobe,
		.overflow, .full, .almost_full_flag, .write_level, .almost_full_threshold_in, .read_request,
		.read_data, .read_valid_strobe, .underflow, .empty, .almost_empty_flag, .read_level,
		.almost_empty_threshold_in, .ext_mem_write_addr, .ext_mem_write_en, .ext_mem_write_data,
		.ext_mem_read_addr, .ext_mem_read_en, .ext_mem_read_data);

	sfc_mem_model mem (.clk_sys, .write_en(ext_mem_write_en), .write_addr(ext_mem_write_addr),
		.write_data(ext_mem_write_data), .read_en(ext_mem_read_en), .read_addr(ext_mem_read_addr),
		.read_data(ext_mem_read_data));

	// The same traffic also runs through the variant with its own cascaded storage blocks.
	sfc_fifo_ctrl #(.EXT_MEM(1'b0), .AF_DYNAMIC(1'b1), .AE_DYNAMIC(1'b1)) dut_im (.clk_sys,
		.read_side_clock(clk_sys), .rstn, .write_request, .write_data, .write_ready(im_ready),
		.write_accepted_strobe(), .overflow(), .full(im_full), .almost_full_flag(), .write_level(),
		.almost_full_threshold_in, .read_request, .read_data(im_read_data), .read_valid_strobe(im_valid),
		.underflow(), .empty(im_empty), .almost_empty_flag(), .read_level(), .almost_empty_threshold_in,
		.ext_mem_write_addr(), .ext_mem_write_en(), .ext_mem_write_data(), .ext_mem_read_addr(),
		.ext_mem_read_en(), .ext_mem_read_data(8'h00));

	initial
	begin
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	function automatic logic af_exp(int n, logic [4:0] t);
		return n >= int'(t);
	endfunction

	function automatic logic ae_exp(int n, logic [4:0] t);
		return n <= int'(t);
	endfunction

	task automatic end_sim;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Scoreboard; refusals must answer exactly one cycle later.
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			q.delete();
			qi.delete();
			taken = 0;
			acks = 0;
			ovf_e = 1'b0;
			udf_e = 1'b0;
		end
		else
		begin
			chk("overflow", 32'(ovf_e), 32'(overflow));
			chk("underflow", 32'(udf_e), 32'(underflow));
			ovf_e = write_request && !write_ready;
			udf_e = read_request && empty;
			if (write_accepted_strobe)
				acks++;
			if (write_request && write_ready)
			begin
				q.push_back(write_data);
				taken++;
			end
			if (write_request && im_ready)
				qi.push_back(write_data);
			if (read_valid_strobe)
				chk("read_data", 32'(q.pop_front()), 32'(read_data));
			if (im_valid)
				chk("im_read_data", 32'(qi.pop_front()), 32'(im_read_data));
		end
	end

	task automatic do_reset(int n);
		@(posedge clk_sys);
		rstn <= 1'b0;
		#1;
		chk("empty", 32'(1), 32'(empty));
		chk("full", 32'(0), 32'(full));
		chk("almost_full_flag", 32'(0), 32'(almost_full_flag));
		repeat (n) @(posedge clk_sys);
		rstn <= 1'b1;
	endtask

	task automatic mix(int n, int pw, int pr);
		repeat (n)
		begin
			@(posedge clk_sys);
			write_request <= ($urandom % 100) < pw;
			write_data <= 8'($urandom);
			read_request <= ($urandom % 100) < pr;
		end
		@(posedge clk_sys);
		write_request <= 1'b0;
		read_request <= 1'b0;
	endtask

	// Reads until every taken word came back, then checks the idle state.
	task automatic drain;
		int n;
		n = 0;
		while (q.size() > 0 && n < 200)
		begin
			@(posedge clk_sys);
			read_request <= 1'b1;
			n++;
		end
		@(posedge clk_sys);
		read_request <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("empty", 32'(1), 32'(empty));
		chk("im_empty", 32'(1), 32'(im_empty));
		chk("read_level", 32'(0), 32'(read_level));
		chk("almost_empty_flag", 32'(ae_exp(0, almost_empty_threshold_in)), 32'(almost_empty_flag));
		chk("acks", 32'(taken), 32'(acks));
		chk("queue", 32'(0), 32'(q.size()));
		chk("im_queue", 32'(0), 32'(qi.size()));
	endtask

	initial
	begin
		void'($urandom(20491));
		almost_full_threshold_in <= 5'(1 + $urandom % 11);
		almost_empty_threshold_in <= 5'(1 + $urandom % 11);
		do_reset(20);
		@(posedge clk_sys);
		read_request <= 1'b1;
		@(posedge clk_sys);
		read_request <= 1'b0;
		mix(20, 100, 0);
		repeat (3) @(posedge clk_sys);
		chk("full", 32'(1), 32'(full));
		chk("im_full", 32'(1), 32'(im_full));
		chk("write_level", 32'(sfc_pkg::DEPTH_CNT), 32'(write_level));
		chk("almost_full_flag", 32'(af_exp(12, almost_full_threshold_in)), 32'(almost_full_flag));
		chk("write_ready", 32'(0), 32'(write_ready));
		drain();
		mix(400, 60, 50);
		drain();
		mix(5, 100, 0);
		repeat (3) @(posedge clk_sys);
		do_reset(3);
		mix(40, 70, 60);
		drain();
		end_sim();
	end

	initial
	begin
		repeat (8000) @(posedge clk_sys);
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
